// ==== pbu_seq.sv ====
`timescale 1ns/1ps
`include "pbu_consts.svh"

module pbu_seq
    import pbu_pkg::*;
#(
    parameter int WORD_W = `PBU_WORD_W,
    parameter logic [`PBU_ADDR_W-1:0] LINK_ADDR = `PBU_LINK_ADDR,
    parameter logic [`PBU_ADDR_W-1:0] START_ADDR = `PBU_RESET_PC
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_mem_ack,
    input wire logic [`PBU_WORD_W-1:0] i_mem_rdata,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [`PBU_ADDR_W-1:0] o_mem_addr,
    output logic [`PBU_WORD_W-1:0] o_mem_wdata,
    output logic [`PBU_ADDR_W-1:0] o_pc,
    output logic [`PBU_WORD_W-1:0] o_acc
);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (WORD_W != `PBU_FUNC_W + `PBU_ADDR_W) begin : g_bad_width
        $error("word must hold exactly the function and address fields");
    end

    if (`PBU_FUNC_MSB != WORD_W - 1 || `PBU_FUNC_LSB != `PBU_ADDR_MSB + 1 || `PBU_ADDR_LSB != 0) begin : g_bad_fields
        $error("function field must sit directly above the address field");
    end

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    pbu_state_type state_q;
    pbu_state_type state_d;
    pbu_word_type ir_q;
    pbu_addr_type pc_q;
    pbu_addr_type pc_d;
    pbu_word_type acc_q;
    pbu_word_type acc_d;
    pbu_func_type func;
    pbu_addr_type operand;
    pbu_addr_type pc_inc;
    pbu_word_type exec_acc;
    logic exec_take;

    assign func = pbu_func_of(ir_q);
    assign operand = pbu_addr_of(ir_q);
    assign pc_inc = pc_q + 13'h0001;
    assign o_pc = pc_q;
    assign o_acc = acc_q;

    pbu_exec u_exec (
        .i_func(func),
        .i_acc(acc_q),
        .i_store(i_mem_rdata),
        .o_acc_next(exec_acc),
        .o_take(exec_take)
    );

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        acc_d = acc_q;
        case (state_q)
            PBU_S_FETCH: begin
                if (i_mem_ack) begin
                    state_d = PBU_S_EXEC;
                end
            end
            PBU_S_EXEC: begin
                case (func)
                    `PBU_FN_REPLACE,
                    `PBU_FN_SUB: begin
                        state_d = PBU_S_OPRD;
                    end
                    `PBU_FN_WRITE: begin
                        state_d = PBU_S_OPWR;
                    end
                    `PBU_FN_UTRAN: begin
                        state_d = PBU_S_LINK;
                    end
                    `PBU_FN_CTRAN: begin
                        state_d = PBU_S_FETCH;
                        pc_d = exec_take ? operand : pc_inc;
                    end
                    default: begin
                        // unimplemented functions simply step on
                        state_d = PBU_S_FETCH;
                        pc_d = pc_inc;
                    end
                endcase
            end
            PBU_S_OPRD: begin
                if (i_mem_ack) begin
                    state_d = PBU_S_FETCH;
                    acc_d = exec_acc;
                    pc_d = pc_inc;
                end
            end
            PBU_S_OPWR: begin
                if (i_mem_ack) begin
                    state_d = PBU_S_FETCH;
                    pc_d = pc_inc;
                end
            end
            PBU_S_LINK: begin
                if (i_mem_ack) begin
                    state_d = PBU_S_FETCH;
                    pc_d = operand;
                end
            end
            default: begin
                state_d = PBU_S_FETCH;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= PBU_S_FETCH;
            pc_q <= START_ADDR;
            acc_q <= `PBU_RESET_ACC;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ir_q <= `PBU_RESET_ACC;
        end else if (state_q == PBU_S_FETCH && i_mem_ack) begin
            ir_q <= i_mem_rdata;
        end
    end

    // ----------------------------------------
    // store port, registered from the next state
    // ----------------------------------------
    // request follows the next state, so it stands unchanged until the ack edge
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_mem_req <= 1'b0;
        end else begin
            o_mem_req <= (state_d != PBU_S_EXEC);
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_mem_we <= 1'b0;
        end else begin
            o_mem_we <= (state_d == PBU_S_OPWR) || (state_d == PBU_S_LINK);
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_mem_addr <= START_ADDR;
        end else begin
            case (state_d)
                PBU_S_FETCH: begin
                    o_mem_addr <= pc_d;
                end
                PBU_S_OPRD,
                PBU_S_OPWR: begin
                    o_mem_addr <= operand;
                end
                PBU_S_LINK: begin
                    o_mem_addr <= LINK_ADDR;
                end
                default: begin
                    o_mem_addr <= pc_d;
                end
            endcase
        end
    end

    // link word carries the return address in its address field
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_mem_wdata <= `PBU_RESET_ACC;
        end else if (state_d == PBU_S_LINK) begin
            o_mem_wdata <= {{`PBU_FUNC_W{1'b0}}, pc_inc};
        end else begin
            o_mem_wdata <= acc_d;
        end
    end

endmodule : pbu_seq

// ==== pbu_consts.svh ====
`ifndef PBU_CONSTS_SVH
`define PBU_CONSTS_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define PBU_WORD_W 18
`define PBU_FUNC_W 5
`define PBU_ADDR_W 13
`define PBU_FUNC_MSB 17
`define PBU_FUNC_LSB 13
`define PBU_ADDR_MSB 12
`define PBU_ADDR_LSB 0

// ----------------------------------------
// function codes
// ----------------------------------------
`define PBU_FN_REPLACE 5'h01
`define PBU_FN_WRITE 5'h02
`define PBU_FN_SUB 5'h04
`define PBU_FN_UTRAN 5'h08
`define PBU_FN_CTRAN 5'h09

// ----------------------------------------
// fixed addresses and reset values
// ----------------------------------------
`define PBU_LINK_ADDR 13'h0000
`define PBU_RESET_PC 13'h0000
`define PBU_RESET_ACC 18'h00000

`endif

// ==== pbu_pkg.sv ====
`include "pbu_consts.svh"

package pbu_pkg;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef logic [`PBU_WORD_W-1:0] pbu_word_type;
    typedef logic [`PBU_ADDR_W-1:0] pbu_addr_type;
    typedef logic [`PBU_FUNC_W-1:0] pbu_func_type;

    typedef enum logic [2:0] {
        PBU_S_FETCH,
        PBU_S_EXEC,
        PBU_S_OPRD,
        PBU_S_OPWR,
        PBU_S_LINK
    } pbu_state_type;

    // ----------------------------------------
    // field decoders
    // ----------------------------------------
    function automatic pbu_func_type pbu_func_of(input pbu_word_type w);
        return w[`PBU_FUNC_MSB:`PBU_FUNC_LSB];
    endfunction : pbu_func_of

    function automatic pbu_addr_type pbu_addr_of(input pbu_word_type w);
        return w[`PBU_ADDR_MSB:`PBU_ADDR_LSB];
    endfunction : pbu_addr_of

endpackage : pbu_pkg

// ==== pbu_exec.sv ====
`timescale 1ns/1ps
`include "pbu_consts.svh"

module pbu_exec
    import pbu_pkg::*;
(
    input wire pbu_func_type i_func,
    input wire pbu_word_type i_acc,
    input wire pbu_word_type i_store,
    output pbu_word_type o_acc_next,
    output logic o_take
);

    // ----------------------------------------
    // accumulator update
    // ----------------------------------------
    always_comb begin
        case (i_func)
            `PBU_FN_REPLACE: o_acc_next = i_store;
            // two's complement fraction; overflow wraps, no flag kept
            `PBU_FN_SUB: o_acc_next = i_acc - i_store;
            default: o_acc_next = i_acc;
        endcase
    end

    // ----------------------------------------
    // sign test: zero has sign bit clear, so it never branches
    // ----------------------------------------
    always_comb begin
        o_take = i_acc[`PBU_WORD_W-1];
    end

endmodule : pbu_exec

// ==== pbu_seq_assertions.sv ====
`timescale 1ns/1ps
`include "pbu_consts.svh"
module pbu_seq_chk #(
    parameter logic [12:0] LINK_ADDR = `PBU_LINK_ADDR
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_mem_ack,
    input wire logic [17:0] i_mem_rdata,
    input wire logic o_mem_req,
    input wire logic o_mem_we,
    input wire logic [12:0] o_mem_addr,
    input wire logic [17:0] o_mem_wdata,
    input wire logic [12:0] o_pc,
    input wire logic [17:0] o_acc
);
    // --------
    // decode tracker
    // --------
    logic ack_q, op_q;
    logic [4:0] fn_q;
    logic [12:0] ad_q, pc_q;
    wire logic rd = o_mem_req && i_mem_ack && !o_mem_we;
    // exec is the idle cycle right after an answered fetch
    wire logic ex = ack_q && !o_mem_req;
    wire logic has_op = fn_q inside {`PBU_FN_REPLACE, `PBU_FN_WRITE, `PBU_FN_SUB, `PBU_FN_UTRAN};
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {ack_q, op_q, fn_q, ad_q, pc_q} <= '0;
        end else begin
            ack_q <= o_mem_req && i_mem_ack;
            if (rd && !op_q) begin
                {fn_q, ad_q} <= i_mem_rdata;
                pc_q <= o_mem_addr;
            end
            if (ex && has_op) begin
                op_q <= 1'b1;
            end else if (i_mem_ack) begin
                op_q <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // --------
    // checks
    // --------
    req_hold_a: assert property (
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable({o_mem_we, o_mem_addr, o_mem_wdata}))
        else $error("request changed before answer");
    seq_step_a: assert property (
        ex && !has_op && fn_q != `PBU_FN_CTRAN |=> o_mem_req && !o_mem_we && o_mem_addr == pc_q + 13'h1)
        else $error("plain function did not step");
    ct_skip_a: assert property (
        ex && fn_q == `PBU_FN_CTRAN && !o_acc[17] |=> o_mem_addr == pc_q + 13'h1)
        else $error("transfer taken on non-negative");
    ct_take_a: assert property (
        ex && fn_q == `PBU_FN_CTRAN && o_acc[17] |=> o_mem_addr == ad_q && o_pc == ad_q)
        else $error("transfer not taken on negative");
    link_save_a: assert property (
        o_mem_req && op_q && fn_q == `PBU_FN_UTRAN |-> o_mem_we && o_mem_addr == LINK_ADDR
        && o_mem_wdata == {5'h00, pc_q + 13'h1}) else $error("bad link write");
    link_jump_a: assert property (
        o_mem_req && i_mem_ack && op_q && fn_q == `PBU_FN_UTRAN |=> o_mem_addr == ad_q && !o_mem_we)
        else $error("no jump after link");
    acc_write_a: assert property (
        o_mem_req && op_q && fn_q == `PBU_FN_WRITE |-> o_mem_we && o_mem_addr == ad_q && o_mem_wdata == o_acc)
        else $error("bad store write");
    acc_sub_a: assert property (
        rd && op_q && fn_q == `PBU_FN_SUB |=> o_acc == $past(o_acc) - $past(i_mem_rdata))
        else $error("bad difference");
    acc_load_a: assert property (
        rd && op_q && fn_q == `PBU_FN_REPLACE |=> o_acc == $past(i_mem_rdata))
        else $error("bad replace");
    cover property (ex && fn_q == `PBU_FN_CTRAN && o_acc == 18'h00000);
    cover property (o_mem_req && i_mem_ack && op_q && fn_q == `PBU_FN_UTRAN);
    cover property (rd && op_q && fn_q == `PBU_FN_SUB);
endmodule : pbu_seq_chk
bind pbu_seq pbu_seq_chk #(.LINK_ADDR(LINK_ADDR)) chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_pc(o_pc), .o_acc(o_acc));

// ==== pbu_store_model.sv ====
`timescale 1ns/1ps
module pbu_store_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [12:0] i_addr,
    input wire logic [17:0] i_wd,
    output logic o_ack = 1'b0,
    output logic [17:0] o_rd = 18'h00000
);
    logic [17:0] mem [0:8191];
    int unsigned wait_q = 0;
    // --------
    // store port
    // --------
    // idle data toggles so a stale word never looks valid
    always @(posedge i_clk) begin
        if (i_req && !o_ack && wait_q == 0) begin
            o_ack <= 1'b1;
            o_rd <= mem[i_addr];
            wait_q <= $urandom_range(2);
            if (i_we) begin
                mem[i_addr] <= i_wd;
            end
        end else begin
            o_ack <= 1'b0;
            o_rd <= ~o_rd;
            if (i_req && !o_ack) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : pbu_store_model

// ==== program_sequencer_branch_unit_bench.sv ====
`timescale 1ns/1ps
`include "pbu_consts.svh"
module program_sequencer_branch_unit_bench;
    // link kept away from the programme at location zero
    localparam logic [12:0] LINK = 13'h0fff;
    typedef struct {logic fe; logic we; logic [12:0] ad; logic [17:0] wd; logic [17:0] ac;} pbu_note_type;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic ack, req, we;
    logic [12:0] addr, pc;
    logic [17:0] rdata, wdata, acc;
    logic [17:0] rm [0:8191];
    pbu_note_type q[$];
    pbu_note_type n;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    always #2 i_clk = ~i_clk;
    pbu_seq #(.LINK_ADDR(LINK)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_mem_ack(ack), .i_mem_rdata(rdata),
        .o_mem_req(req), .o_mem_we(we), .o_mem_addr(addr), .o_mem_wdata(wdata), .o_pc(pc), .o_acc(acc));
    pbu_store_model store_u (.i_clk(i_clk), .i_req(req), .i_we(we), .i_addr(addr), .i_wd(wdata),
        .o_ack(ack), .o_rd(rdata));
    // --------
    // helpers
    // --------
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    // reference run: notes every store access in order
    task automatic iss(input int cnt);
        logic [12:0] p;
        logic [17:0] a, w;
        p = 13'h0000;
        a = 18'h00000;
        repeat (cnt) begin
            w = rm[p];
            q.push_back('{1'b1, 1'b0, p, 18'h0, a});
            p = p + 13'h1;
            if (w[17:13] == `PBU_FN_REPLACE || w[17:13] == `PBU_FN_SUB) begin
                q.push_back('{1'b0, 1'b0, w[12:0], 18'h0, a});
            end
            case (w[17:13])
                `PBU_FN_REPLACE: a = rm[w[12:0]];
                `PBU_FN_SUB: a = a - rm[w[12:0]];
                `PBU_FN_WRITE: begin
                    q.push_back('{1'b0, 1'b1, w[12:0], a, a});
                    rm[w[12:0]] = a;
                end
                `PBU_FN_UTRAN: begin
                    q.push_back('{1'b0, 1'b1, LINK, {5'h00, p}, a});
                    rm[LINK] = {5'h00, p};
                    p = w[12:0];
                end
                `PBU_FN_CTRAN: if (a[17]) p = w[12:0];
                default: ;
            endcase
        end
    endtask : iss
    always @(negedge i_clk) begin
        if (req === 1'b1 && ack === 1'b1 && q.size() > 0) begin
            n = q.pop_front();
            chk("we", {17'h0, n.we}, {17'h0, we});
            chk("addr", {5'h00, n.ad}, {5'h00, addr});
            chk("acc", n.ac, acc);
            if (n.we) chk("wdata", n.wd, wdata);
            if (n.fe) chk("pc", {5'h00, n.ad}, {5'h00, pc});
        end
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // --------
    // main
    // --------
    // zero acc, skip; negative acc, branch to top; write; link wraps to 0; subtract to zero at 5
    initial begin
        void'($urandom(32'h815c));
        for (int i = 0; i < 8192; i++) rm[i] = 18'($urandom);
        rm[0] = {`PBU_FN_REPLACE, 13'h0010};
        rm[1] = {`PBU_FN_CTRAN, 13'h1ffe};
        rm[2] = {`PBU_FN_REPLACE, 13'h0011};
        rm[3] = {`PBU_FN_CTRAN, 13'h1ffe};
        rm[5] = {`PBU_FN_SUB, 13'h0011};
        rm[16] = 18'h00000;
        rm[17] = 18'h20000;
        rm[8190] = {`PBU_FN_WRITE, 13'h0012};
        rm[8191] = {`PBU_FN_UTRAN, 13'h0005};
        for (int i = 0; i < 8192; i++) store_u.mem[i] = rm[i];
        iss(400);
        repeat (16) @(negedge i_clk);
        i_nrst = 1'b1;
        for (int k = 0; k < 15000 && q.size() > 0; k++) @(negedge i_clk);
        if (q.size() > 0) error_cnt++;
        end_of_test();
    end
endmodule : program_sequencer_branch_unit_bench
